// File: verilog/ipg_pkg.sv
// constants for the interrupt priority register group
`default_nettype none
package ipg_pkg;
    localparam int          NUM_SRC       = 3;
    localparam int          LVL_W         = 3;
    localparam int          REG_W         = 16;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 32;
    // byte addresses
    localparam logic [3:0]  OFS_PRIO      = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    // priority fields inside the control word
    localparam int          TMR2_LSB      = 12;
    localparam int          OC2_LSB       = 8;
    localparam int          IC2_LSB       = 4;
    // writable bits of the control word
    localparam logic [15:0] PRIO_MASK     = 16'h7770;
    localparam logic [2:0]  LVL_RESET     = 3'h4;
    localparam logic [2:0]  LVL_OFF       = 3'h0;
    // status word layout
    localparam int          ST_PEND_LSB   = 0;
    localparam int          ST_VALID_BIT  = 4;
    localparam int          ST_SRC_LSB    = 8;
    localparam int          ST_LVL_LSB    = 12;
    // source indices and response codes
    localparam logic [1:0]  SRC_TMR2      = 2'h0;
    localparam logic [1:0]  SRC_OC2       = 2'h1;
    localparam logic [1:0]  SRC_IC2       = 2'h2;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ipg_pkg
`default_nettype wire

// File: verilog/ipg_level_if.sv
// carrier between the register file and the priority resolver
`default_nettype none
interface ipg_level_if;
    logic [ipg_pkg::LVL_W-1:0]   level [ipg_pkg::NUM_SRC];
    logic [ipg_pkg::NUM_SRC-1:0] req;
    logic [ipg_pkg::NUM_SRC-1:0] pend;
    logic                        win_valid;
    logic [1:0]                  win_src;
    logic [ipg_pkg::LVL_W-1:0]   win_level;

    modport owner (
        output level,
        output req,
        input  pend,
        input  win_valid,
        input  win_src,
        input  win_level
    );
    modport resolver (
        input  level,
        input  req,
        output pend,
        output win_valid,
        output win_src,
        output win_level
    );
endinterface : ipg_level_if
`default_nettype wire

// File: verilog/ipg_resolver.sv
// picks the highest enabled pending source from the priority levels
`default_nettype none
module ipg_resolver (
    ipg_level_if.resolver lv
);
    // strict greater keeps the lowest index on a tie
    function automatic logic higher(
        input logic [ipg_pkg::LVL_W-1:0] cand,
        input logic [ipg_pkg::LVL_W-1:0] best
    );
        higher = cand > best;
    endfunction

    always_comb begin
        lv.win_valid = 1'b0;
        lv.win_src   = ipg_pkg::SRC_TMR2;
        lv.win_level = ipg_pkg::LVL_OFF;
        for (int i = 0; i < ipg_pkg::NUM_SRC; i++) begin
            lv.pend[i] = lv.req[i] && (lv.level[i] != ipg_pkg::LVL_OFF);
            if (lv.pend[i] && higher(lv.level[i], lv.win_level)) begin
                lv.win_valid = 1'b1;
                lv.win_src   = 2'(i);
                lv.win_level = lv.level[i];
            end
        end
    end
endmodule : ipg_resolver
`default_nettype wire

// File: verilog/ipg_priority_regs.sv
// axi4-lite priority register for three interrupt sources with resolver
`default_nettype none
// Function
// - timer2 level field in bits 14 to 12, read and write.
// - output compare 2 level field in bits 10 to 8, read and write.
// - input capture 2 level field in bits 6 to 4, read and write.
// - field value 111 means level 7, the highest.
// - 001 is level 1, lowest active; values between rise in order.
// - field value 000 disables the source entirely.
module ipg_priority_regs (
    input  wire logic                             clk,
    input  wire logic                             reset,
    input  wire logic [ipg_pkg::ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic [2:0]                       s_axi_awprot,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [ipg_pkg::DATA_W-1:0]       s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [ipg_pkg::ADDR_W-1:0]       s_axi_araddr,
    input  wire logic [2:0]                       s_axi_arprot,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [ipg_pkg::DATA_W-1:0]            s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    input  wire logic [ipg_pkg::NUM_SRC-1:0]      src_req,
    output logic [ipg_pkg::LVL_W-1:0]             timer2_irq_level,
    output logic [ipg_pkg::LVL_W-1:0]             outcmp2_irq_level,
    output logic [ipg_pkg::LVL_W-1:0]             incap2_irq_level,
    output logic [ipg_pkg::NUM_SRC-1:0]           src_enabled,
    output logic                                  irq_valid,
    output logic [1:0]                            irq_src,
    output logic [ipg_pkg::LVL_W-1:0]             irq_level
);
    // write path holding registers
    logic                        aw_full_q;
    logic [ipg_pkg::ADDR_W-1:0]  aw_addr_q;
    logic                        w_full_q;
    logic [ipg_pkg::DATA_W-1:0]  w_data_q;
    logic [3:0]                  w_strb_q;
    logic                        awready_q;
    logic                        wready_q;
    logic                        bvalid_q;
    logic [1:0]                  bresp_q;
    // read path
    logic                        arready_q;
    logic                        rvalid_q;
    logic [ipg_pkg::DATA_W-1:0]  rdata_q;
    logic [1:0]                  rresp_q;
    // stored fields
    logic [ipg_pkg::LVL_W-1:0]   tmr2_q;
    logic [ipg_pkg::LVL_W-1:0]   oc2_q;
    logic [ipg_pkg::LVL_W-1:0]   ic2_q;
    // registered resolver result and source enable flags
    logic [ipg_pkg::NUM_SRC-1:0] pend_q;
    logic                        win_valid_q;
    logic [1:0]                  win_src_q;
    logic [ipg_pkg::LVL_W-1:0]   win_level_q;
    logic [ipg_pkg::NUM_SRC-1:0] enabled_q;

    logic                        aw_take;
    logic                        w_take;
    logic                        aw_full_d;
    logic                        w_full_d;
    logic                        wr_fire;
    logic                        ar_take;
    logic                        rvalid_d;
    logic [15:0]                 prio_word;
    logic [15:0]                 status_word;
    logic [15:0]                 merged;
    logic                        prio_wr;

    ipg_level_if lv ();

    // merge byte lanes onto the current control word
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        lane_merge = res;
    endfunction

    function automatic logic mapped(
        input logic [ipg_pkg::ADDR_W-1:0] addr
    );
        mapped = (addr == ipg_pkg::OFS_PRIO) || (addr == ipg_pkg::OFS_STATUS);
    endfunction

    function automatic logic hits_prio(
        input logic [ipg_pkg::ADDR_W-1:0] addr
    );
        hits_prio = addr == ipg_pkg::OFS_PRIO;
    endfunction

    function automatic logic level_on(
        input logic [ipg_pkg::LVL_W-1:0] level
    );
        level_on = level != ipg_pkg::LVL_OFF;
    endfunction

    assign aw_take   = s_axi_awvalid && awready_q;
    assign w_take    = s_axi_wvalid && wready_q;
    // perform only once the last write answer has been taken
    assign wr_fire   = aw_full_q && w_full_q && !bvalid_q;
    assign aw_full_d = aw_take || (aw_full_q && !wr_fire);
    assign w_full_d  = w_take || (w_full_q && !wr_fire);
    assign ar_take   = s_axi_arvalid && arready_q;
    assign rvalid_d  = ar_take || (rvalid_q && !s_axi_rready);
    assign prio_wr   = wr_fire && hits_prio(aw_addr_q);

    always_comb begin
        prio_word = 16'h0000;
        prio_word[ipg_pkg::TMR2_LSB +: ipg_pkg::LVL_W] = tmr2_q;
        prio_word[ipg_pkg::OC2_LSB +: ipg_pkg::LVL_W]  = oc2_q;
        prio_word[ipg_pkg::IC2_LSB +: ipg_pkg::LVL_W]  = ic2_q;
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[ipg_pkg::ST_PEND_LSB +: ipg_pkg::NUM_SRC] = pend_q;
        status_word[ipg_pkg::ST_VALID_BIT]                    = win_valid_q;
        status_word[ipg_pkg::ST_SRC_LSB +: 2]                 = win_src_q;
        status_word[ipg_pkg::ST_LVL_LSB +: ipg_pkg::LVL_W]    = win_level_q;
    end

    assign merged = lane_merge(prio_word, w_data_q, w_strb_q) & ipg_pkg::PRIO_MASK;

    // write address channel
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b0;
            aw_addr_q <= '0;
        end else begin
            aw_full_q <= aw_full_d;
            awready_q <= !aw_full_d;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
        end
    end

    // write data channel
    always_ff @(posedge clk) begin
        if (reset) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            w_full_q <= w_full_d;
            wready_q <= !w_full_d;
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // write response channel
    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ipg_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= hits_prio(aw_addr_q) ? ipg_pkg::RESP_OKAY
                                             : ipg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tmr2_q <= ipg_pkg::LVL_RESET;
        end else if (prio_wr) begin
            tmr2_q <= merged[ipg_pkg::TMR2_LSB +: ipg_pkg::LVL_W];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            oc2_q <= ipg_pkg::LVL_RESET;
        end else if (prio_wr) begin
            oc2_q <= merged[ipg_pkg::OC2_LSB +: ipg_pkg::LVL_W];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ic2_q <= ipg_pkg::LVL_RESET;
        end else if (prio_wr) begin
            ic2_q <= merged[ipg_pkg::IC2_LSB +: ipg_pkg::LVL_W];
        end
    end

    // read handshake
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            rvalid_q  <= rvalid_d;
            arready_q <= !rvalid_d;
        end
    end

    // read data captured at the take
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= '0;
            rresp_q <= ipg_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rresp_q <= mapped(s_axi_araddr) ? ipg_pkg::RESP_OKAY
                                            : ipg_pkg::RESP_SLVERR;
            if (hits_prio(s_axi_araddr)) begin
                rdata_q <= {16'h0000, prio_word};
            end else if (s_axi_araddr == ipg_pkg::OFS_STATUS) begin
                rdata_q <= {16'h0000, status_word};
            end else begin
                rdata_q <= '0;
            end
        end
    end

    // feed the resolver
    assign lv.level[ipg_pkg::SRC_TMR2] = tmr2_q;
    assign lv.level[ipg_pkg::SRC_OC2]  = oc2_q;
    assign lv.level[ipg_pkg::SRC_IC2]  = ic2_q;
    assign lv.req                      = src_req;

    ipg_resolver u_resolver (
        .lv (lv.resolver)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            enabled_q <= '0;
        end else begin
            enabled_q[ipg_pkg::SRC_TMR2] <= level_on(tmr2_q);
            enabled_q[ipg_pkg::SRC_OC2]  <= level_on(oc2_q);
            enabled_q[ipg_pkg::SRC_IC2]  <= level_on(ic2_q);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pend_q      <= '0;
            win_valid_q <= 1'b0;
            win_src_q   <= ipg_pkg::SRC_TMR2;
            win_level_q <= ipg_pkg::LVL_OFF;
        end else begin
            pend_q      <= lv.pend;
            win_valid_q <= lv.win_valid;
            win_src_q   <= lv.win_src;
            win_level_q <= lv.win_level;
        end
    end

    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rdata       = rdata_q;
    assign s_axi_rresp       = rresp_q;
    assign timer2_irq_level  = tmr2_q;
    assign outcmp2_irq_level = oc2_q;
    assign incap2_irq_level  = ic2_q;
    assign src_enabled       = enabled_q;
    assign irq_valid         = win_valid_q;
    assign irq_src           = win_src_q;
    assign irq_level         = win_level_q;

endmodule : ipg_priority_regs
`default_nettype wire

// File: dv/ipg_priority_regs_chk.sv
// assertions on the ports of the priority register block
`default_nettype none
module ipg_priority_regs_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [2:0]  src_req,
    input wire logic [2:0]  timer2_irq_level,
    input wire logic [2:0]  outcmp2_irq_level,
    input wire logic [2:0]  incap2_irq_level,
    input wire logic [2:0]  src_enabled,
    input wire logic        irq_valid,
    input wire logic [1:0]  irq_src,
    input wire logic [2:0]  irq_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lv [3];
    logic [2:0] en_now;
    logic [2:0] pend;
    logic [2:0] best_l;
    logic [1:0] best_s;
    assign lv[0] = timer2_irq_level;
    assign lv[1] = outcmp2_irq_level;
    assign lv[2] = incap2_irq_level;
    assign en_now = {lv[2] != 3'h0, lv[1] != 3'h0, lv[0] != 3'h0};
    assign pend = src_req & en_now;
    // highest level wins, lowest index on a tie
    always_comb begin
        best_l = 3'h0;
        best_s = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (pend[i] && lv[i] > best_l) begin
                best_l = lv[i];
                best_s = 2'(i);
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_prio;
        rd_take ##0 s_axi_araddr == ipg_pkg::OFS_PRIO;
    endsequence
    chk_lvl_reset: assert property (
        $fell(reset) |-> {lv[0], lv[1], lv[2]} == 9'h124)
        else $error("fields not 100 after reset");
    chk_rdata_prio: assert property (
        rd_prio |=> s_axi_rdata == {17'h0, $past(timer2_irq_level), 1'b0,
            $past(outcmp2_irq_level), 1'b0, $past(incap2_irq_level), 4'h0})
        else $error("priority word read wrong");
    chk_en_track: assert property (
        !$past(reset) |-> src_enabled == $past(en_now))
        else $error("src_enabled wrong");
    chk_irq_valid: assert property (
        !$past(reset) |-> irq_valid == |$past(pend))
        else $error("irq_valid wrong");
    chk_irq_pick: assert property (
        !$past(reset) |-> irq_src == $past(best_s) && irq_level == $past(best_l))
        else $error("wrong winner");
    chk_read_lat: assert property (rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    chk_w_block: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("write data taken twice");
endmodule // ipg_priority_regs_chk
bind ipg_priority_regs ipg_priority_regs_chk u_ipg_priority_regs_chk (.*);
`default_nettype wire

// File: dv/ipg_priority_regs_tb.sv
// testbench for the priority register block
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module ipg_priority_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset = 1'b1, slow = 1'b0;
    logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
    logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0, src_req = '0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, irq_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_src;
    logic [2:0]  timer2_irq_level, outcmp2_irq_level, incap2_irq_level;
    logic [2:0]  src_enabled, irq_level;
    int          failures = 0;
    int          n_tests = 0;

    ipg_priority_regs u_ipg_priority_regs (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int t;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (t == 4) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && t < 40);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bvalid, 1'b1)
        `CHK(s_axi_bresp, er)
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int t;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (t == 4) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && t < 40);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rvalid, 1'b1)
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
    endtask

    // load levels, raise requests, check winner and status word
    task automatic arb(input logic [15:0] w, input logic [2:0] r, input logic [2:0] p,
                       input logic v, input logic [1:0] s, input logic [2:0] l);
        wr(ipg_pkg::OFS_PRIO, {16'h0, w}, 4'h3, ipg_pkg::RESP_OKAY);
        src_req <= r;
        repeat (2) @(posedge clk);
        #1;
        `CHK({irq_valid, irq_src, irq_level}, {v, s, l})
        rd(ipg_pkg::OFS_STATUS, {17'h0, l, 2'h0, s, 3'h0, v, 1'h0, p}, ipg_pkg::RESP_OKAY);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(ipg_pkg::OFS_PRIO, 32'h0000_4440, ipg_pkg::RESP_OKAY);
        `CHK({timer2_irq_level, outcmp2_irq_level, incap2_irq_level}, 9'h124)
        rd(ipg_pkg::OFS_STATUS, 32'h0000_0000, ipg_pkg::RESP_OKAY);
        $display("test reset values done");
        for (int v = 0; v < 8; v++) begin
            logic [2:0] lv;
            lv = v[2:0];
            wr(ipg_pkg::OFS_PRIO, {16'hFFFF, 1'b1, lv, 1'b1, lv, 1'b1, lv, 4'hF}, 4'hF,
               ipg_pkg::RESP_OKAY);
            rd(ipg_pkg::OFS_PRIO, {17'h0, lv, 1'b0, lv, 1'b0, lv, 4'h0},
               ipg_pkg::RESP_OKAY);
            #1;
            `CHK({timer2_irq_level, outcmp2_irq_level, incap2_irq_level}, {3{lv}})
            `CHK(src_enabled, {3{lv != 3'h0}})
        end
        $display("test field values done");
        wr(ipg_pkg::OFS_PRIO, 32'h0000_0050, 4'h1, ipg_pkg::RESP_OKAY);
        rd(ipg_pkg::OFS_PRIO, 32'h0000_7750, ipg_pkg::RESP_OKAY);
        wr(ipg_pkg::OFS_PRIO, 32'h0000_2000, 4'h2, ipg_pkg::RESP_OKAY);
        rd(ipg_pkg::OFS_PRIO, 32'h0000_2050, ipg_pkg::RESP_OKAY);
        $display("test byte strobes done");
        slow = 1'b1;
        wr(4'h8, 32'hFFFF_FFFF, 4'hF, ipg_pkg::RESP_SLVERR);
        wr(ipg_pkg::OFS_STATUS, 32'hFFFF_FFFF, 4'hF, ipg_pkg::RESP_SLVERR);
        rd(4'h8, 32'h0000_0000, ipg_pkg::RESP_SLVERR);
        rd(ipg_pkg::OFS_PRIO, 32'h0000_2050, ipg_pkg::RESP_OKAY);
        slow = 1'b0;
        $display("test refused accesses done");
        arb(16'h3730, 3'h7, 3'h7, 1'b1, 2'h1, 3'h7);
        arb(16'h3730, 3'h5, 3'h5, 1'b1, 2'h0, 3'h3);
        arb(16'h3030, 3'h2, 3'h0, 1'b0, 2'h0, 3'h0);
        arb(16'h1020, 3'h5, 3'h5, 1'b1, 2'h2, 3'h2);
        arb(16'h1000, 3'h1, 3'h1, 1'b1, 2'h0, 3'h1);
        arb(16'h0000, 3'h7, 3'h0, 1'b0, 2'h0, 3'h0);
        $display("test arbitration done");
        give_verdict();
    end

    initial begin
        #(20_000 * 5);
        failures++;
        $display("Error at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule // ipg_priority_regs_tb
`default_nettype wire
